// file: opm_pkg.sv
// Package for the operating-mode select and bus configuration block.
// Assumes a single 100 MHz clock and an E-cycle enable made by a divider.
package opm_pkg;

	// ==========================================================
	// Mode encodings
	localparam logic [2:0] OPM_MODE0 = 3'h0;
	localparam logic [2:0] OPM_MODE1 = 3'h1;
	localparam logic [2:0] OPM_MODE2 = 3'h2;
	localparam logic [2:0] OPM_MODE3 = 3'h3;
	localparam logic [2:0] OPM_MODE4 = 3'h4;
	localparam logic [2:0] OPM_MODE5 = 3'h5;
	localparam logic [2:0] OPM_MODE6 = 3'h6;
	localparam logic [2:0] OPM_MODE7 = 3'h7;

	// ==========================================================
	// Fundamental bus kinds, one-hot
	typedef enum logic [2:0] {
		OPM_SINGLE = 3'b001,
		OPM_NMUX = 3'b010,
		OPM_MUX = 3'b100
	} opm_bus_t;

	// ==========================================================
	// Register area and field positions
	localparam int OPM_P2_MODE_LSB = 5;
	localparam int OPM_REG_AREA_SIZE = 32;
	localparam logic [15:0] OPM_REG_AREA_HI = 16'h001f;
	localparam logic [15:0] OPM_MODE3_REG_BASE = 16'hc000;
	localparam logic [7:0] OPM_RAM_LO = 8'h80;
	localparam logic [15:0] OPM_EXT_LO = 16'h0100;
	localparam logic [15:0] OPM_EXT_HI = 16'h01ff;
	localparam logic [15:0] OPM_RESET_VEC = 16'hfffe;
	localparam logic [15:0] OPM_RESET_VEC_M0 = 16'hbffe;
	localparam logic [15:0] OPM_VEC_BASE = 16'hfff0;
	localparam logic [15:0] OPM_VEC_BASE_M0 = 16'hbff0;
	localparam logic [7:0] OPM_DDR_RESET = 8'h00;
	localparam int OPM_IO_LINES_SINGLE = 21;

	// ==========================================================
	// Timing: E clock derived from the 100 MHz system clock
	localparam int OPM_CLK_MHZ = 100;
	localparam int OPM_E_DIV = 4;
	localparam int OPM_SYNC_DEPTH = 2;
	localparam int OPM_RST_MIN_E_TENTHS = 30;
	localparam int OPM_SETUP_MIN_E_TENTHS = 20;
	localparam int OPM_RST_MIN_E = (OPM_RST_MIN_E_TENTHS + 9) / 10;
	localparam int OPM_SETUP_MIN_E = (OPM_SETUP_MIN_E_TENTHS + 9) / 10;

endpackage

// file: opm_ediv.sv
// E-cycle enable divider.
// Assumes the single system clock; emits one-cycle enable pulses.
`timescale 1ns/1ns
`default_nettype none
module opm_ediv import opm_pkg::*; (
	input wire logic i_clk,     // System clock.
	input wire logic i_rst_b,   // Synchronous reset, active low.
	output logic o_e_tick,      // One-cycle pulse per E cycle.
	output logic o_e_high       // E phase level.
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb begin
		cnt_nxt = cnt_r + 2'h1;
		tick_nxt = (cnt_r == 2'(OPM_E_DIV - 1));
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cnt_r <= 2'h0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_e_tick = tick_r;
	assign o_e_high = cnt_r[1];
endmodule
`default_nettype wire

// file: opm_sync.sv
// Two-flop synchroniser for a bus of pin levels.
// Assumes the destination is the system clock domain.
`timescale 1ns/1ns
`default_nettype none
module opm_sync #(
	parameter int W = 3
) (
	input wire logic i_clk,          // System clock.
	input wire logic i_rst_b,        // Synchronous reset, active low.
	input wire logic [W-1:0] i_d,    // Asynchronous levels.
	output logic [W-1:0] o_q         // Synchronised levels.
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
		end
	end

	assign o_q = s2_r;
endmodule
`default_nettype wire

// file: opm_mode_select.sv
// Operating-mode latch and port/strobe/bus configuration decode.
// Assumes the CPU core supplies an internal address and access strobes.
// Operation
// - Capture three mode pin levels into latched mode bits on reset release.
// - Latched mode bits read back in the top of the Port 2 data byte.
// - Pins decode to modes 7..0; modes 2,3 external ROM, 1 external vectors.
// - Modes 4,7 single-chip; 5 non-multiplexed; others multiplexed.
// - Single-chip ports are parallel I/O, no external address or data bus.
// - Mode 4 drops ROM, RAM decodes at XX80-XXFF, reset vector from RAM.
// - In mode 4, writing Port 2 bit 5 switches permanently to mode 5.
// - Mode 5: Port 3 data bus, Port 4 bits output A0-A7 per direction bit.
// - Mode 5 external space 100-1FF asserts the I/O-select strobe.
// - Multiplexed modes: Port 3 carries low address then data, 64K space.
// - Modes 0-3 drive Port 4 as A8-A15 permanently.
// - Mode 6 Port 4 direction bit n outputs A8+n, zeros stay inputs.
// - Mode 0 reset vector from BFFE, internal and external buses joined.
// - First 32 locations of each map are the internal register area, except mode 3 at C000-C01F.
// - Strobe pins: single IS3/OS3, non-mux EXTERNAL_IO_SELECT and R/W, mux AS and R/W.
// - The mode steers memory map, ports 3 and 4, strobes and vectors.
// - In mux modes first strobe is address strobe input, second R/W out.
`timescale 1ns/1ns
`default_nettype none
module opm_mode_select import opm_pkg::*; (
	input wire logic i_clk,                 // System clock, 100 MHz.
	input wire logic i_rst_b,               // Synchronous reset, active low.
	input wire logic i_mode_pin_lsb,        // Mode pin, bit 0, async.
	input wire logic i_mode_pin_mid,        // Mode pin, bit 1, async.
	input wire logic i_mode_pin_msb,        // Mode pin, bit 2, async.
	input wire logic [15:0] i_cpu_addr,     // Internal CPU address.
	input wire logic i_cpu_valid,           // CPU access this cycle.
	input wire logic i_cpu_wr,              // CPU access is a write.
	input wire logic [7:0] i_cpu_wdata,     // CPU write data.
	input wire logic [4:0] i_port2_pins,    // Port 2 pin levels, same clock.
	input wire logic [7:0] i_port4_ddr,     // Port 4 direction register.
	input wire logic [7:0] i_port4_out,     // Port 4 user output data.
	input wire logic [7:0] i_port3_out,     // Port 3 user output data.
	input wire logic i_port3_rd,            // Port 3 data register read.
	input wire logic i_port3_wr,            // Port 3 data register write.
	input wire logic i_oss,                 // Output strobe on write when set.
	input wire logic i_strobe_ctrl_first,   // First strobe pin input level.
	output logic [2:0] o_mode,              // Current operating mode.
	output logic o_latched_mode_bit0,       // Latched mode bit 0.
	output logic o_latched_mode_bit1,       // Latched mode bit 1.
	output logic o_latched_mode_bit2,       // Latched mode bit 2.
	output logic [7:0] o_port2_rdata,       // Port 2 data register read value.
	output logic o_single_chip,             // Single-chip bus kind.
	output logic o_nmux,                    // Non-multiplexed bus kind.
	output logic o_mux,                     // Multiplexed bus kind.
	output logic o_rom_en,                  // Internal ROM in the map.
	output logic o_rom_ext,                 // ROM located externally.
	output logic o_vec_ext,                 // Vectors located externally.
	output logic [15:0] o_reset_vec,        // Reset vector fetch address.
	output logic [15:0] o_vec_base,         // Interrupt vector base.
	output logic o_reg_sel,                 // Access hits register area.
	output logic o_ram_sel,                 // Access hits RAM in mode 4.
	output logic o_ext_sel,                 // Access goes off chip.
	output logic o_bus_join,                // Internal/external buses joined.
	output logic [7:0] o_port3_out,         // Port 3 output data.
	output logic [7:0] o_port3_oe,          // Port 3 drive enables.
	output logic [7:0] o_port4_out,         // Port 4 output data.
	output logic [7:0] o_port4_oe,          // Port 4 drive enables.
	output logic o_strobe_ctrl_first,       // First strobe pin output.
	output logic o_strobe_ctrl_first_oe,    // First strobe pin enable.
	output logic o_strobe_ctrl_second,      // Second strobe pin output.
	output logic o_strobe_ctrl_second_oe,   // Second strobe pin enable.
	output logic o_port3_input_strobe,      // Input strobe level, single chip.
	output logic o_addr_latch_strobe,       // Address strobe level, mux.
	output logic o_e_tick                   // E-cycle enable pulse.
);

	// ==========================================================
	// Helpers
	function automatic opm_bus_t bus_of(input logic [2:0] m);
		if (m == OPM_MODE4 || m == OPM_MODE7)
			return OPM_SINGLE;
		else if (m == OPM_MODE5)
			return OPM_NMUX;
		else
			return OPM_MUX;
	endfunction

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
			input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// ==========================================================
	// Pin synchronisers and E divider
	logic [2:0] pins_s;
	logic [0:0] sc1_s;
	logic e_tick;
	logic e_high;

	opm_sync #(.W(3)) u_mode_sync (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_d({i_mode_pin_msb, i_mode_pin_mid, i_mode_pin_lsb}),
		.o_q(pins_s)
	);

	opm_sync #(.W(1)) u_sc1_sync (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_d(i_strobe_ctrl_first),
		.o_q(sc1_s)
	);

	opm_ediv u_ediv (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.o_e_tick(e_tick),
		.o_e_high(e_high)
	);

	// ==========================================================
	// Mode latch
	// The synchronisers are cleared by reset, so the pins are taken only once
	// both stages have refilled after release. This stands in for the reset
	// rising edge and costs a few cycles of start-up delay.
	logic [2:0] mode_r;
	logic [2:0] mode_nxt;
	logic cap_r;
	logic cap_nxt;
	logic [1:0] capw_r;
	logic [1:0] capw_nxt;
	logic p2_set_wr;

	// Software escape from mode 4: a write of the Port 2 data byte with bit 5
	// set. Nothing else moves the mode once it has been taken.
	assign p2_set_wr = i_cpu_valid && i_cpu_wr && (i_cpu_addr == {8'h00, 8'h03}) &&
		i_cpu_wdata[OPM_P2_MODE_LSB];

	always_comb begin
		mode_nxt = mode_r;
		cap_nxt = cap_r;
		capw_nxt = capw_r;
		if (cap_r) begin
			if (capw_r == 2'(OPM_SYNC_DEPTH)) begin
				mode_nxt = pins_s;
				cap_nxt = 1'b0;
			end else begin
				capw_nxt = capw_r + 2'h1;
			end
		end else if (mode_r == OPM_MODE4 && p2_set_wr) begin
			mode_nxt = OPM_MODE5;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			mode_r <= OPM_MODE7;
			cap_r <= 1'b1;
			capw_r <= 2'h0;
		end else begin
			mode_r <= mode_nxt;
			cap_r <= cap_nxt;
			capw_r <= capw_nxt;
		end
	end

	// ==========================================================
	// Mode decode
	opm_bus_t bus;
	logic [15:0] reg_base;

	always_comb begin
		bus = bus_of(mode_r);
		o_rom_en = (mode_r != OPM_MODE4) && (mode_r != OPM_MODE2) &&
			(mode_r != OPM_MODE3);
		o_rom_ext = (mode_r == OPM_MODE2) || (mode_r == OPM_MODE3);
		o_vec_ext = (mode_r <= OPM_MODE3);
		o_vec_base = (mode_r == OPM_MODE0) ? OPM_VEC_BASE_M0 : OPM_VEC_BASE;
		o_reset_vec = OPM_RESET_VEC;
		if (mode_r == OPM_MODE0)
			o_reset_vec = OPM_RESET_VEC_M0;
		// Mode 0 ties both data buses; the system must keep the maps apart.
		o_bus_join = (mode_r == OPM_MODE0);
		reg_base = (mode_r == OPM_MODE3) ? OPM_MODE3_REG_BASE : 16'h0000;
		o_reg_sel = i_cpu_valid && in_range(i_cpu_addr, reg_base,
			reg_base + OPM_REG_AREA_HI);
		o_ram_sel = i_cpu_valid && (mode_r == OPM_MODE4) &&
			(i_cpu_addr[7:0] >= OPM_RAM_LO);
		o_ext_sel = 1'b0;
		unique case (bus)
			OPM_SINGLE: o_ext_sel = 1'b0;
			OPM_NMUX: o_ext_sel = i_cpu_valid &&
				in_range(i_cpu_addr, OPM_EXT_LO, OPM_EXT_HI);
			OPM_MUX: o_ext_sel = i_cpu_valid && !o_reg_sel;
		endcase
	end

	// ==========================================================
	// Port and strobe pin configuration
	logic [7:0] p3_out_nxt;
	logic [7:0] p3_oe_nxt;
	logic [7:0] p4_out_nxt;
	logic [7:0] p4_oe_nxt;
	logic sc1_nxt;
	logic sc1_oe_nxt;
	logic sc2_nxt;
	logic sc2_oe_nxt;
	logic [7:0] p3_out_r;
	logic [7:0] p3_oe_r;
	logic [7:0] p4_out_r;
	logic [7:0] p4_oe_r;
	logic sc1_r;
	logic sc1_oe_r;
	logic sc2_r;
	logic sc2_oe_r;

	always_comb begin
		p3_out_nxt = i_port3_out;
		p3_oe_nxt = 8'h00;
		p4_out_nxt = i_port4_out;
		p4_oe_nxt = i_port4_ddr;
		sc1_nxt = 1'b0;
		sc1_oe_nxt = 1'b0;
		sc2_nxt = 1'b1;
		sc2_oe_nxt = 1'b1;
		unique case (bus)
			OPM_SINGLE: begin
				p3_oe_nxt = 8'hff;
				// Output strobe pulses low on the selected data register access.
				sc2_nxt = !(i_oss ? i_port3_wr : i_port3_rd);
			end
			OPM_NMUX: begin
				p3_out_nxt = i_cpu_wdata;
				p3_oe_nxt = {8{o_ext_sel && i_cpu_wr && e_high}};
				p4_out_nxt = i_cpu_addr[7:0];
				p4_oe_nxt = i_port4_ddr;
				sc1_nxt = !o_ext_sel;
				sc1_oe_nxt = 1'b1;
				sc2_nxt = !(o_ext_sel && i_cpu_wr);
			end
			OPM_MUX: begin
				// Address before E, write data while E high, high-Z on reads while E high.
				p3_out_nxt = e_high ? i_cpu_wdata : i_cpu_addr[7:0];
				p3_oe_nxt = {8{o_ext_sel && (!e_high || i_cpu_wr)}};
				p4_out_nxt = i_cpu_addr[15:8];
				// Mode 6 leaves unopened address lines as inputs for user data.
				if (mode_r == OPM_MODE6)
					p4_oe_nxt = i_port4_ddr;
				else
					p4_oe_nxt = 8'hff;
				sc2_nxt = !(o_ext_sel && i_cpu_wr);
			end
		endcase
		if (bus == OPM_SINGLE)
			p4_oe_nxt = i_port4_ddr;
		// Port 4 drives nothing until the mode is known, so no stale map leaks out.
		if (cap_r)
			p4_oe_nxt = OPM_DDR_RESET;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			p3_out_r <= 8'h00;
			p3_oe_r <= 8'h00;
			p4_out_r <= 8'h00;
			p4_oe_r <= 8'h00;
			sc1_r <= 1'b0;
			sc1_oe_r <= 1'b0;
			sc2_r <= 1'b1;
			sc2_oe_r <= 1'b0;
		end else begin
			p3_out_r <= p3_out_nxt;
			p3_oe_r <= p3_oe_nxt;
			p4_out_r <= p4_out_nxt;
			p4_oe_r <= p4_oe_nxt;
			sc1_r <= sc1_nxt;
			sc1_oe_r <= sc1_oe_nxt;
			sc2_r <= sc2_nxt;
			sc2_oe_r <= sc2_oe_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign o_mode = mode_r;
	assign o_latched_mode_bit0 = mode_r[0];
	assign o_latched_mode_bit1 = mode_r[1];
	assign o_latched_mode_bit2 = mode_r[2];
	assign o_port2_rdata = {mode_r, i_port2_pins};
	assign o_single_chip = (bus == OPM_SINGLE);
	assign o_nmux = (bus == OPM_NMUX);
	assign o_mux = (bus == OPM_MUX);
	assign o_port3_out = p3_out_r;
	assign o_port3_oe = p3_oe_r;
	assign o_port4_out = p4_out_r;
	assign o_port4_oe = p4_oe_r;
	assign o_strobe_ctrl_first = sc1_r;
	assign o_strobe_ctrl_first_oe = sc1_oe_r;
	assign o_strobe_ctrl_second = sc2_r;
	assign o_strobe_ctrl_second_oe = sc2_oe_r;
	assign o_port3_input_strobe = (bus == OPM_SINGLE) && sc1_s[0];
	assign o_addr_latch_strobe = (bus == OPM_MUX) && sc1_s[0];
	assign o_e_tick = e_tick;
endmodule
`default_nettype wire

// file: opm_props.sv
// Concurrent checks on the ports of the operating-mode select block.
// Assumes one clock and a synchronous active-low reset; bound to every instance.
`timescale 1ns/1ns
`default_nettype none
module opm_props import opm_pkg::*; (
	input wire logic i_clk, // Clock.
	input wire logic i_rst_b, // Reset.
	input wire logic [15:0] i_cpu_addr, // Address.
	input wire logic i_cpu_valid, // Access.
	input wire logic i_cpu_wr, // Write.
	input wire logic [7:0] i_cpu_wdata, // Data.
	input wire logic [7:0] i_port4_ddr, // Port 4 direction.
	input wire logic [2:0] o_mode, // Mode.
	input wire logic o_latched_mode_bit0, // Bit 0.
	input wire logic o_latched_mode_bit1, // Bit 1.
	input wire logic o_latched_mode_bit2, // Bit 2.
	input wire logic [7:0] o_port2_rdata, // Port 2 read.
	input wire logic o_single_chip, // Kind.
	input wire logic o_nmux, // Kind.
	input wire logic o_mux, // Kind.
	input wire logic o_rom_en, // ROM mapped.
	input wire logic o_rom_ext, // ROM outside.
	input wire logic o_vec_ext, // Vectors outside.
	input wire logic [15:0] o_reset_vec, // Reset vector.
	input wire logic o_bus_join, // Buses joined.
	input wire logic o_reg_sel, // Register hit.
	input wire logic o_ram_sel, // RAM hit.
	input wire logic [7:0] o_port4_oe, // Port 4 enables.
	input wire logic o_strobe_ctrl_first, // First strobe.
	input wire logic o_strobe_ctrl_first_oe, // First enable.
	input wire logic o_strobe_ctrl_second_oe // Second enable.
);
	// ==========================================================
	// Helpers
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	logic sw_hit;
	assign sw_hit = o_mode == OPM_MODE4 && i_cpu_valid && i_cpu_wr
		&& i_cpu_addr == 16'h0003 && i_cpu_wdata[5];
	// Four high samples put the capture cycle safely behind us.
	sequence s_settled; i_rst_b [*4]; endsequence
	sequence s_io_mode; o_mode[2] ##1 o_mode[2]; endsequence
	sequence s_addr_mode; o_mode <= OPM_MODE3 ##1 o_mode <= OPM_MODE3; endsequence
	// ==========================================================
	// Properties
	property p_mode_hold; s_settled ##0 !sw_hit |=> $stable(o_mode); endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode moved without cause");
	property p_switch; sw_hit |=> o_mode == OPM_MODE5; endproperty
	a_switch: assert property (p_switch) else $error("mode switch missed");
	property p_bits; o_port2_rdata[7:5] == o_mode
		&& {o_latched_mode_bit2, o_latched_mode_bit1, o_latched_mode_bit0} == o_mode; endproperty
	a_bits: assert property (p_bits) else $error("mode bits differ");
	property p_kind; o_single_chip == (o_mode == OPM_MODE4 || o_mode == OPM_MODE7)
		&& o_nmux == (o_mode == OPM_MODE5) && o_mux == (o_mode <= OPM_MODE3 || o_mode == OPM_MODE6);
	endproperty
	a_kind: assert property (p_kind) else $error("bus kind wrong");
	property p_map; o_vec_ext == (o_mode <= OPM_MODE3) && o_bus_join == (o_mode == OPM_MODE0)
		&& o_rom_ext == (o_mode == OPM_MODE2 || o_mode == OPM_MODE3); endproperty
	a_map: assert property (p_map) else $error("map placement wrong");
	property p_vec0; o_mode == OPM_MODE0 |-> o_reset_vec == OPM_RESET_VEC_M0; endproperty
	a_vec0: assert property (p_vec0) else $error("mode 0 reset vector wrong");
	property p_p4_addr; s_settled ##0 s_addr_mode |=> o_port4_oe == 8'hff; endproperty
	a_p4_addr: assert property (p_p4_addr) else $error("port 4 not address");
	property p_p4_ddr; s_settled ##0 s_io_mode |=> o_port4_oe == $past(i_port4_ddr); endproperty
	a_p4_ddr: assert property (p_p4_ddr) else $error("port 4 enables wrong");
	property p_strobe; s_settled |=> o_strobe_ctrl_second_oe
		&& o_strobe_ctrl_first_oe == ($past(o_mode) == OPM_MODE5); endproperty
	a_strobe: assert property (p_strobe) else $error("strobe pin roles wrong");
	property p_ios; s_settled ##0 o_mode == OPM_MODE5 |=> o_strobe_ctrl_first
		== !($past(i_cpu_valid) && $past(i_cpu_addr) >= OPM_EXT_LO
		&& $past(i_cpu_addr) <= OPM_EXT_HI); endproperty
	a_ios: assert property (p_ios) else $error("select strobe wrong");
	property p_ram; o_mode == OPM_MODE4 && i_cpu_valid && i_cpu_addr[7]
		|-> o_ram_sel && !o_rom_en; endproperty
	a_ram: assert property (p_ram) else $error("test mode RAM decode wrong");
	property p_reg; i_cpu_valid && o_mode != OPM_MODE3 && i_cpu_addr <= OPM_REG_AREA_HI
		|-> o_reg_sel; endproperty
	a_reg: assert property (p_reg) else $error("register area missed");
endmodule
bind opm_mode_select opm_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_cpu_addr(i_cpu_addr), .i_cpu_valid(i_cpu_valid), .i_cpu_wr(i_cpu_wr),
	.i_cpu_wdata(i_cpu_wdata), .i_port4_ddr(i_port4_ddr), .o_mode(o_mode),
	.o_latched_mode_bit0(o_latched_mode_bit0), .o_latched_mode_bit1(o_latched_mode_bit1),
	.o_latched_mode_bit2(o_latched_mode_bit2), .o_port2_rdata(o_port2_rdata),
	.o_single_chip(o_single_chip), .o_nmux(o_nmux), .o_mux(o_mux), .o_rom_en(o_rom_en),
	.o_rom_ext(o_rom_ext), .o_vec_ext(o_vec_ext), .o_reset_vec(o_reset_vec),
	.o_bus_join(o_bus_join), .o_reg_sel(o_reg_sel), .o_ram_sel(o_ram_sel),
	.o_port4_oe(o_port4_oe), .o_strobe_ctrl_first(o_strobe_ctrl_first),
	.o_strobe_ctrl_first_oe(o_strobe_ctrl_first_oe),
	.o_strobe_ctrl_second_oe(o_strobe_ctrl_second_oe));
`default_nettype wire

// file: opm_ext_side.sv
// External-side model: mode programming levels and an address strobe source.
// Assumes the bench changes the wanted mode only while reset is held low.
`timescale 1ns/1ns
`default_nettype none
module opm_ext_side (
	input wire logic i_clk, // Clock.
	input wire logic [2:0] i_mode_req, // Wanted mode.
	input wire logic i_as_en, // Strobe enable.
	output logic [2:0] o_pins, // Mode pin levels.
	output logic o_as // Strobe level.
);
	logic [1:0] ph_r = 2'h0;
	// Levels follow the request at once, well ahead of reset release.
	assign o_pins = i_mode_req;
	always_ff @(posedge i_clk) begin
		ph_r <= ph_r + 2'h1;
	end
	assign o_as = i_as_en && ph_r == 2'h0;
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the operating-mode select block.
// Assumes the package, the design, the bound checker and the model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb import opm_pkg::*;;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic valid = 1'b0;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] ddr = 8'h00;
	logic [4:0] p2 = 5'h00;
	logic [2:0] mreq = 3'h7;
	logic oss = 1'b0;
	logic p3wr = 1'b0;
	int err_total = 0;
	int cmp_count = 0;
	wire logic [2:0] pins, mode;
	wire logic [7:0] p2rd, p4oe;
	wire logic [15:0] rvec, vbase;
	wire logic as_lvl, lb0, lb1, lb2, sc, nm, mx, romen, rext, vext, regsel, ramsel, bjoin;
	wire logic s1, s1oe, s2, s2oe, esel;
	opm_ext_side ext_u (.i_clk(i_clk), .i_mode_req(mreq), .i_as_en(1'b1), .o_pins(pins),
		.o_as(as_lvl));
	opm_mode_select dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_mode_pin_lsb(pins[0]),
		.i_mode_pin_mid(pins[1]), .i_mode_pin_msb(pins[2]), .i_cpu_addr(addr),
		.i_cpu_valid(valid), .i_cpu_wr(wr), .i_cpu_wdata(wdata), .i_port2_pins(p2),
		.i_port4_ddr(ddr), .i_port4_out(8'h00), .i_port3_out(8'h00), .i_port3_rd(1'b0),
		.i_port3_wr(p3wr), .i_oss(oss), .i_strobe_ctrl_first(as_lvl), .o_mode(mode),
		.o_latched_mode_bit0(lb0), .o_latched_mode_bit1(lb1), .o_latched_mode_bit2(lb2),
		.o_port2_rdata(p2rd), .o_single_chip(sc), .o_nmux(nm), .o_mux(mx), .o_rom_en(romen),
		.o_rom_ext(rext), .o_vec_ext(vext), .o_reset_vec(rvec), .o_vec_base(vbase),
		.o_reg_sel(regsel), .o_ram_sel(ramsel), .o_ext_sel(esel), .o_bus_join(bjoin),
		.o_port3_out(), .o_port3_oe(), .o_port4_out(), .o_port4_oe(p4oe),
		.o_strobe_ctrl_first(s1), .o_strobe_ctrl_first_oe(s1oe), .o_strobe_ctrl_second(s2),
		.o_strobe_ctrl_second_oe(s2oe), .o_port3_input_strobe(), .o_addr_latch_strobe(),
		.o_e_tick());
	always #5 i_clk = ~i_clk;
	// ==========================================================
	// Tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("mismatches %0d comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Pins change at the start of reset, so they are long settled at release.
	task boot(input logic [2:0] m);
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		mreq <= m;
		p2 <= 5'h15 ^ {2'h0, m};
		ddr <= 8'h5a ^ {5'h00, m};
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
	endtask
	task acc(input logic [15:0] a, input logic w, input logic [7:0] d);
		@(posedge i_clk);
		addr <= a;
		wr <= w;
		wdata <= d;
		valid <= 1'b1;
		#1;
	endtask
	task rel;
		@(posedge i_clk);
		valid <= 1'b0;
		#1;
	endtask
	// ==========================================================
	// Sequence
	initial begin
		for (int m = 0; m < 8; m++) begin
			boot(m[2:0]);
			chk(mode, m[2:0]);
			chk({lb2, lb1, lb0}, m[2:0]);
			chk(p2rd, {m[2:0], p2});
			chk({sc, nm, mx}, {m == 4 || m == 7, m == 5, m < 4 || m == 6});
			chk({vext, rext, bjoin}, {m < 4, m == 2 || m == 3, m == 0});
			chk(rvec, m == 0 ? OPM_RESET_VEC_M0 : OPM_RESET_VEC);
			chk(vbase, m == 0 ? OPM_VEC_BASE_M0 : OPM_VEC_BASE);
			chk(p4oe, m < 4 ? 8'hff : ddr);
			chk({s1oe, s2oe}, {m == 5, 1'b1});
			acc(m == 3 ? 16'hc010 : 16'h001f, 1'b0, 8'h00);
			chk(regsel, 1'b1);
			chk(esel, 1'b0);
			rel;
		end
		@(posedge i_clk);
		oss <= 1'b1;
		p3wr <= 1'b1;
		@(posedge i_clk);
		p3wr <= 1'b0;
		#1;
		chk(s2, 1'b0);
		@(posedge i_clk);
		#1;
		chk(s2, 1'b1);
		acc(16'h0003, 1'b1, 8'h20);
		rel;
		chk(mode, OPM_MODE7);
		boot(OPM_MODE4);
		acc(16'h2b90, 1'b0, 8'h00);
		chk({ramsel, romen}, 2'b10);
		acc(16'h0003, 1'b1, 8'hdf);
		rel;
		chk(mode, OPM_MODE4);
		acc(16'h0003, 1'b1, 8'h20);
		rel;
		chk(mode, OPM_MODE5);
		acc(16'h0150, 1'b0, 8'h00);
		chk(esel, 1'b1);
		rel;
		chk(s1, 1'b0);
		acc(16'h0200, 1'b0, 8'h00);
		chk(esel, 1'b0);
		rel;
		chk(s1, 1'b1);
		chk(p4oe, ddr);
		conclude();
	end
	initial begin
		#100000;
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		conclude();
	end
endmodule
`default_nettype wire
